// ==== rtl/slw_cfg.svh ====
// Constants of the strap latch and wake signalling block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SLW_CFG_SVH
`define SLW_CFG_SVH

`define SLW_OFF_CTRL 8'h00
`define SLW_OFF_STRAP 8'h04
`define SLW_OFF_INT_STATUS 8'h08
`define SLW_OFF_INT_MASK 8'h0C

`define SLW_CTRL_PME_BIT 0
`define SLW_CTRL_APM_BIT 1
`define SLW_CTRL_RESET 2'h0

`define SLW_STRAP_EEPROM_BIT 0
`define SLW_STRAP_AUX_BIT 1
`define SLW_STRAP_VALID_BIT 2
`define SLW_STRAP_REFOK_BIT 3
`define SLW_STRAP_PWRGOOD_BIT 4

`define SLW_INT_WAKE_BIT 0
`define SLW_INT_LATCH_BIT 1
`define SLW_INT_WIDTH 2
`define SLW_INT_RESET 2'h0

`define SLW_REF_CLOCK_MHZ 100
`define SLW_CORE_CLOCK_LO_MHZ 125
`define SLW_CORE_CLOCK_HI_MHZ 250
`define SLW_REF_LOCK_EDGES 16

`endif

// ==== rtl/slw_pkg.sv ====
// Types shared by the strap latch and wake signalling block.
// Assumes nothing beyond a SystemVerilog compiler.
package slw_pkg;

   typedef struct packed {
      logic memory_type_strap;
      logic aux_power_strap;
   } slw_strap_type;

   typedef struct packed {
      logic mem_is_eeprom;
      logic aux_power_supported;
   } slw_cfg_type;

   typedef struct packed {
      logic ref_clock_pos;
      logic ref_clock_neg;
   } slw_refclk_type;

endpackage : slw_pkg

// ==== rtl/slw_refclk_mon.sv ====
// Reference clock monitor standing in for the link core clock generator.
// Assumes the reference pair is sampled synchronously to pclk.
`timescale 1ns/1ps
`include "slw_cfg.svh"
module slw_refclk_mon #(
   parameter int LOCK_EDGES = `SLW_REF_LOCK_EDGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire slw_pkg::slw_refclk_type ref_clock,
   output logic ref_ok
);
   import slw_pkg::*;

   logic ref_q;
   logic [7:0] edge_count;
   wire ref_level = ref_clock.ref_clock_pos & ~ref_clock.ref_clock_neg;
   wire ref_edge = ref_level ^ ref_q;
   wire lock_hit = edge_count == 8'(LOCK_EDGES - 1);

   // Core clocks are only declared good after a run of reference edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q <= 1'b0;
         edge_count <= 8'h00;
         ref_ok <= 1'b0;
      end else begin
         ref_q <= ref_level;
         if (!run) begin
            edge_count <= 8'h00;
            ref_ok <= 1'b0;
         end else if (ref_edge && !ref_ok) begin
            edge_count <= edge_count + 8'h01;
            ref_ok <= lock_hit;
         end
      end
   end

endmodule : slw_refclk_mon

// ==== rtl/slw_top.sv ====
// Strap capture, wake request and APB registers of the network controller.
// Assumes APB master on pclk and pins synchronous to pclk.
`timescale 1ns/1ps
`include "slw_cfg.svh"
module slw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_clock_good_reset_n,
   input wire slw_pkg::slw_strap_type strap_pins,
   input wire slw_pkg::slw_refclk_type ref_clock,
   input wire logic wake_event,
   output logic scan_clock,
   output logic scan_mode_select,
   output logic wake_request_n_out,
   output logic wake_request_n_oe,
   output slw_pkg::slw_cfg_type strap_cfg,
   output logic power_good,
   output logic irq
);
   import slw_pkg::*;

   // Assertions sample on pclk and rest while presetn is low.
   default clocking cb_pclk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic rst_q;
   logic cfg_valid;
   slw_strap_type shadow;
   logic [1:0] ctrl;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic ref_ok;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = a == off;
   endfunction : hit

   wire in_window = !power_clock_good_reset_n;
   wire release_edge = power_clock_good_reset_n && !rst_q;
   wire access = psel && penable && !pready;
   // Writes land at the edge that samples ready, which ends the transfer.
   wire done = psel && penable && pready;
   wire wr = done && pwrite;
   wire sel_ctrl = hit(paddr, `SLW_OFF_CTRL);
   wire sel_strap = hit(paddr, `SLW_OFF_STRAP);
   wire sel_ist = hit(paddr, `SLW_OFF_INT_STATUS);
   wire sel_imask = hit(paddr, `SLW_OFF_INT_MASK);
   wire mapped = sel_ctrl | sel_strap | sel_ist | sel_imask;
   wire wake_enabled = ctrl[`SLW_CTRL_PME_BIT] | ctrl[`SLW_CTRL_APM_BIT];
   wire wake_set = wake_event && wake_enabled;
   wire [1:0] set_bits = {release_edge, wake_set};
   wire [1:0] clr_bits = (wr && sel_ist) ? pwdata[1:0] : 2'h0;
   // A set arriving with a clear is kept.
   wire [1:0] next_int_status = (int_status & ~clr_bits) | set_bits;
   wire [31:0] strap_word = {27'h0, power_good, ref_ok, cfg_valid,
                             strap_cfg.aux_power_supported,
                             strap_cfg.mem_is_eeprom};
   wire [31:0] next_rdata = sel_ctrl ? {30'h0, ctrl} :
                            sel_strap ? strap_word :
                            sel_ist ? {30'h0, int_status} :
                            sel_imask ? {30'h0, int_mask} : 32'h0;

   slw_refclk_mon u_refclk (
      .pclk(pclk),
      .presetn(presetn),
      .run(power_clock_good_reset_n),
      .ref_clock(ref_clock),
      .ref_ok(ref_ok)
   );

   // Strap shadow follows the pins only while the reset input is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // A reset input already high at start-up is not a release.
         rst_q <= 1'b1;
         shadow <= '0;
         strap_cfg <= '0;
         cfg_valid <= 1'b0;
         power_good <= 1'b0;
      end else begin
         rst_q <= power_clock_good_reset_n;
         power_good <= power_clock_good_reset_n;
         if (in_window) begin
            shadow <= strap_pins;
            cfg_valid <= 1'b0;
         end
         if (release_edge) begin
            strap_cfg.mem_is_eeprom <= shadow.memory_type_strap;
            strap_cfg.aux_power_supported <= shadow.aux_power_strap;
            cfg_valid <= 1'b1;
         end
      end
   end

   // Scan port sees the pins only outside the sampling window.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_clock <= 1'b0;
         scan_mode_select <= 1'b0;
      end else begin
         scan_clock <= in_window ? 1'b0 : strap_pins.aux_power_strap;
         scan_mode_select <= in_window ? 1'b0 :
                             strap_pins.memory_type_strap;
      end
   end

   // The wake pin only ever pulls low; the data bit stays zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_request_n_out <= 1'b0;
         wake_request_n_oe <= 1'b0;
      end else begin
         wake_request_n_out <= 1'b0;
         wake_request_n_oe <= next_int_status[`SLW_INT_WAKE_BIT];
      end
   end

   // Control and mask change only at the edge that completes a write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SLW_CTRL_RESET;
         int_status <= `SLW_INT_RESET;
         int_mask <= `SLW_INT_RESET;
         irq <= 1'b0;
      end else begin
         int_status <= next_int_status;
         irq <= |(next_int_status & int_mask);
         if (wr && sel_ctrl) begin
            ctrl <= pwdata[1:0];
         end
         if (wr && sel_imask) begin
            int_mask <= pwdata[1:0];
         end
      end
   end

   // Every access has one wait state; the answer stands for one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
         prdata <= (access && !pwrite) ? next_rdata : 32'h0;
      end
   end

   // Counts cycles since the latch so the hold check starts after it.
   logic [3:0] hold_count;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_count <= 4'h0;
      end else if (power_clock_good_reset_n && cfg_valid &&
                   hold_count != 4'hF) begin
         hold_count <= hold_count + 4'h1;
      end else if (!power_clock_good_reset_n) begin
         hold_count <= 4'h0;
      end
   end

   // Checks below use the default clock and reset declared at the top.
   AST_LATCH_TAKES_LAST: assert property (
      release_edge |=>
      strap_cfg.mem_is_eeprom == $past(shadow.memory_type_strap))
      else $error("Memory type not latched at release.");

   AST_SCAN_GATED: assert property (
      in_window |=> !scan_clock && !scan_mode_select)
      else $error("Scan port active inside reset window.");

   AST_WAKE_NEEDS_ENABLE: assert property (
      $rose(wake_request_n_oe) |-> $past(wake_enabled))
      else $error("Wake pulled without enable.");

   AST_WAKE_SET: assert property (
      wake_event && wake_enabled |=> wake_request_n_oe)
      else $error("Wake event did not pull the line.");

   AST_OPEN_DRAIN: assert property (
      !wake_request_n_out)
      else $error("Wake line driven high.");

   AST_PWR_GOOD: assert property (
      $rose(power_clock_good_reset_n) |=> power_good)
      else $error("Power good missing after release.");

   AST_AUX: assert property (
      release_edge |=>
      strap_cfg.aux_power_supported == $past(shadow.aux_power_strap))
      else $error("Aux power strap wrong.");

   AST_HOLD: assert property (
      hold_count != 4'h0 && power_clock_good_reset_n |=> $stable(strap_cfg))
      else $error("Latched straps changed outside reset.");

   AST_APB_ONE: assert property (
      pready |=> !pready)
      else $error("Ready held two cycles.");

   COV_LATCH: cover property (release_edge);
   COV_WAKE: cover property ($rose(wake_request_n_oe));
   COV_REFUSED: cover property (wake_event && !wake_enabled);
   COV_IRQ: cover property ($rose(irq));
   COV_REF: cover property ($rose(ref_ok));

endmodule : slw_top

// ==== test/slw_host_model.sv ====
// Host side model: power/clock good reset, reference pair, strap pins.
// Assumes the bench drives hold_reset and strap_set just after pclk rises.
`timescale 1ns/1ps
module slw_host_model (
   input wire logic pclk,
   input wire logic hold_reset,
   input wire slw_pkg::slw_strap_type strap_set,
   input wire logic wake_oe,
   output slw_pkg::slw_refclk_type ref_clock,
   output logic pcg_reset_n,
   output slw_pkg::slw_strap_type strap_pins,
   output logic wake_line
);
   import slw_pkg::*;
   logic [2:0] cnt = 3'h0;
   initial ref_clock = 2'h1;
   initial pcg_reset_n = 1'b0;
   // The shared line has a pull-up; the device only ever pulls it low.
   assign wake_line = wake_oe ? 1'b0 : 1'b1;
   assign strap_pins = strap_set;
   always @(posedge pclk) begin
      ref_clock <= ~ref_clock;
      cnt <= hold_reset ? 3'h0 : (cnt == 3'h4 ? cnt : cnt + 3'h1);
      // Reset is released only once the reference clock has been running.
      pcg_reset_n <= !hold_reset && cnt == 3'h4;
   end
endmodule : slw_host_model

// ==== test/slw_top_tb.sv ====
// Self-checking bench of the strap latch and wake block.
// Assumes slw_cfg.svh is found on the include path.
`timescale 1ns/1ps
`include "slw_cfg.svh"
module slw_top_tb;
   import slw_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, hold_reset, wake_event, pcg_reset_n;
   logic scan_clock, scan_mode_select, oe, wout, wake_line, power_good, irq;
   slw_strap_type strap_set = 2'h0;
   slw_strap_type strap_pins;
   slw_refclk_type ref_clock;
   slw_cfg_type strap_cfg;
   int n_errors = 0;
   int n_checks = 0;
   initial hold_reset = 1'b1;
   initial wake_event = 1'b0;
   always #12.5 pclk = ~pclk;
   slw_host_model u_slw_host_model (.pclk(pclk), .hold_reset(hold_reset),
      .strap_set(strap_set), .wake_oe(oe), .ref_clock(ref_clock),
      .pcg_reset_n(pcg_reset_n), .strap_pins(strap_pins),
      .wake_line(wake_line));
   slw_top u_slw_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_clock_good_reset_n(pcg_reset_n), .strap_pins(strap_pins),
      .ref_clock(ref_clock), .wake_event(wake_event),
      .scan_clock(scan_clock), .scan_mode_select(scan_mode_select),
      .wake_request_n_out(wout), .wake_request_n_oe(oe),
      .strap_cfg(strap_cfg), .power_good(power_good), .irq(irq));
   task results;
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_errors++;
         results();
      end
   endtask : apb
   task automatic capture(input slw_strap_type s);
      int i;
      @(posedge pclk);
      strap_set <= s;
      hold_reset <= 1'b1;
      repeat (3) @(posedge pclk);
      cmp({power_good, scan_mode_select, scan_clock}, 32'h0);
      hold_reset <= 1'b0;
      i = 0;
      while (pcg_reset_n !== 1'b1 && i < 50) begin
         @(posedge pclk);
         i++;
      end
      if (i >= 50) begin
         n_errors++;
         results();
      end
      repeat (2) @(posedge pclk);
   endtask : capture
   task t_straps;
      capture(2'b10);
      cmp(strap_cfg, 32'h2);
      cmp(power_good, 32'h1);
      apb(1'b0, `SLW_OFF_STRAP, 32'h0, rd, err);
      cmp(rd & 32'h17, 32'h15);
      apb(1'b0, `SLW_OFF_INT_STATUS, 32'h0, rd, err);
      cmp(rd, 32'h2);
      strap_set <= 2'b01;
      repeat (3) @(posedge pclk);
      cmp(strap_cfg, 32'h2);
      cmp({scan_mode_select, scan_clock}, 32'h1);
      capture(2'b01);
      cmp(strap_cfg, 32'h1);
      apb(1'b1, `SLW_OFF_INT_STATUS, 32'h2, rd, err);
   endtask : t_straps
   task t_wake;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `SLW_OFF_INT_MASK, k % 2, rd, err);
         apb(1'b1, `SLW_OFF_CTRL, k, rd, err);
         @(posedge pclk);
         wake_event <= 1'b1;
         @(posedge pclk);
         wake_event <= 1'b0;
         @(negedge pclk);
         cmp({oe, wake_line, irq}, k ? {31'h2, k[0]} : 32'h2);
         cmp(wout, 32'h0);
         apb(1'b1, `SLW_OFF_INT_STATUS, 32'h1, rd, err);
         @(negedge pclk);
         cmp({oe, wake_line, irq}, 32'h2);
      end
      apb(1'b0, `SLW_OFF_STRAP, 32'h0, rd, err);
      cmp(rd[3], 32'h1);
   endtask : t_wake
   task t_regs;
      apb(1'b0, `SLW_OFF_INT_MASK, 32'h0, rd, err);
      cmp(rd, 32'h1);
      cmp(err, 32'h0);
      apb(1'b1, 8'h10, 32'h0, rd, err);
      cmp(err, 32'h1);
      apb(1'b0, `SLW_OFF_CTRL, 32'h0, rd, err);
      cmp(rd, 32'h3);
      apb(1'b0, 8'h10, 32'h0, rd, err);
      cmp(rd, 32'h0);
      cmp(err, 32'h1);
   endtask : t_regs
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SLW_OFF_CTRL, 32'h0, rd, err);
      cmp(rd, 32'h0);
      t_straps();
      t_wake();
      t_regs();
      results();
   end
endmodule : slw_top_tb
